/* File: asr_host.sv */
// Host controller driving a 64K x 16 asynchronous static memory.
`timescale 1ns/1ns
`default_nettype none
`include "asr_params.svh"
// Summary of operation
// - Reads and writes spaced at least 70 ns, address stable.
// - Address and select 60 ns before write end; strobe low 50 ns.
// - Active byte selects held low 60 ns before write end.
// - Write data stable 30 ns before end, held 0 ns after.
// - Address valid no later than write start.
// - Write ends at first rising control; address held for recovery.
// - Select-started read has address valid at select fall.
module asr_host (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic rst_i,
    // User request side.
    input wire logic req_i,
    input wire logic req_write_i,
    input wire logic [`ASR_ADDR_W-1:0] req_addr_i,
    input wire logic [`ASR_DATA_W-1:0] req_wdata_i,
    input wire logic [1:0] req_be_i,
    output logic req_ready_o,
    output logic rsp_valid_o,
    output logic [`ASR_DATA_W-1:0] rsp_rdata_o,
    // Memory pins.
    output logic [`ASR_ADDR_W-1:0] word_index_o,
    output logic chip_sel_n_o,
    output logic out_gate_n_o,
    output logic write_strobe_n_o,
    output logic low_byte_sel_n_o,
    output logic high_byte_sel_n_o,
    input wire logic [`ASR_DATA_W-1:0] shared_data_bus_i,
    output logic [`ASR_DATA_W-1:0] shared_data_bus_o,
    output logic shared_data_bus_oe_o
);
    asr_pkg::asr_state_t state, next_state;
    logic [2:0] cnt, next_cnt;
    logic [`ASR_ADDR_W-1:0] addr, next_addr;
    logic [`ASR_DATA_W-1:0] wdata, next_wdata, rdata, next_rdata;
    logic [1:0] be, next_be;
    logic valid, next_valid;

    // A request carrying no byte enable would leave the memory in standby, so both lanes are used.
    function automatic logic [1:0] norm_be(input logic [1:0] b);
        norm_be = (b == 2'h0) ? 2'h3 : b;
    endfunction : norm_be

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_addr = addr;
        next_wdata = wdata;
        next_rdata = rdata;
        next_be = be;
        next_valid = 1'b0;
        case (state)
            asr_pkg::ASR_IDLE: begin
                if (req_i) begin
                    // Address, data and lanes latch on the same edge at which the selects fall.
                    next_addr = req_addr_i;
                    next_wdata = req_wdata_i;
                    next_be = norm_be(req_be_i);
                    next_state = req_write_i ? asr_pkg::ASR_WR : asr_pkg::ASR_RD;
                    next_cnt = req_write_i ? `ASR_WP_CYC : `ASR_RD_CYC;
                end
            end
            asr_pkg::ASR_RD: begin
                if (cnt == `ASR_CNT_ONE) begin
                    // Sampled only once the full access time has passed.
                    next_rdata = shared_data_bus_i;
                    next_valid = 1'b1;
                    next_state = asr_pkg::ASR_GAP;
                    next_cnt = `ASR_GAP_CYC;
                end else begin
                    next_cnt = cnt - `ASR_CNT_ONE;
                end
            end
            asr_pkg::ASR_WR: begin
                if (cnt == `ASR_CNT_ONE) begin
                    next_state = asr_pkg::ASR_WEND;
                end else begin
                    next_cnt = cnt - `ASR_CNT_ONE;
                end
            end
            asr_pkg::ASR_WEND: begin
                next_state = asr_pkg::ASR_GAP;
                next_cnt = `ASR_GAP_CYC;
            end
            asr_pkg::ASR_GAP: begin
                if (cnt == `ASR_CNT_ONE) begin
                    next_state = asr_pkg::ASR_IDLE;
                end else begin
                    next_cnt = cnt - `ASR_CNT_ONE;
                end
            end
            default: begin
                next_state = asr_pkg::ASR_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= asr_pkg::ASR_IDLE;
            cnt <= `ASR_CNT_ZERO;
            addr <= 16'h0000;
            wdata <= 16'h0000;
            rdata <= 16'h0000;
            be <= 2'h0;
            valid <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            addr <= next_addr;
            wdata <= next_wdata;
            rdata <= next_rdata;
            be <= next_be;
            valid <= next_valid;
        end
    end

    logic in_rd, in_wr, in_cyc;
    assign in_rd = (state == asr_pkg::ASR_RD);
    assign in_wr = (state == asr_pkg::ASR_WR);
    // Selects stay low through the write-end cycle so strobe rises first and ends the write.
    assign in_cyc = in_rd || in_wr || (state == asr_pkg::ASR_WEND);

    assign req_ready_o = (state == asr_pkg::ASR_IDLE);
    assign rsp_valid_o = valid;
    assign rsp_rdata_o = rdata;
    assign word_index_o = addr;
    assign chip_sel_n_o = ~in_cyc;
    assign low_byte_sel_n_o = ~(in_cyc && be[0]);
    assign high_byte_sel_n_o = ~(in_cyc && be[1]);
    assign out_gate_n_o = ~in_rd;
    assign write_strobe_n_o = ~in_wr;
    assign shared_data_bus_o = wdata;
    // Host drives the bus across the write end and one cycle after, never during a read.
    assign shared_data_bus_oe_o = in_wr || (state == asr_pkg::ASR_WEND);

    // The strobe is one clock wide, which already exceeds the least pulse width.
    property p_wr_len;
        @(posedge mclk_i) disable iff (rst_i)
        $fell(write_strobe_n_o) |-> !write_strobe_n_o ##1 write_strobe_n_o;
    endproperty : p_wr_len
    a_wr_len: assert property (p_wr_len) else $error("strobe width wrong");

    property p_wr_sel;
        @(posedge mclk_i) disable iff (rst_i)
        $rose(write_strobe_n_o) |-> !chip_sel_n_o;
    endproperty : p_wr_sel
    a_wr_sel: assert property (p_wr_sel) else $error("select rose before strobe");

    property p_addr;
        @(posedge mclk_i) disable iff (rst_i)
        !chip_sel_n_o && !$past(chip_sel_n_o) |-> $stable(word_index_o);
    endproperty : p_addr
    a_addr: assert property (p_addr) else $error("address moved in cycle");

    property p_no_fight;
        @(posedge mclk_i) disable iff (rst_i)
        !out_gate_n_o |-> !shared_data_bus_oe_o;
    endproperty : p_no_fight
    a_no_fight: assert property (p_no_fight) else $error("bus driven during read");

    property p_data;
        @(posedge mclk_i) disable iff (rst_i)
        !write_strobe_n_o |=> $stable(shared_data_bus_o) && shared_data_bus_oe_o;
    endproperty : p_data
    a_data: assert property (p_data) else $error("write data not held");

    property p_rd_len;
        @(posedge mclk_i) disable iff (rst_i)
        $fell(out_gate_n_o) |-> ##1 rsp_valid_o;
    endproperty : p_rd_len
    a_rd_len: assert property (p_rd_len) else $error("read not timed");

    property p_gap;
        @(posedge mclk_i) disable iff (rst_i)
        $rose(chip_sel_n_o) |-> chip_sel_n_o [*2];
    endproperty : p_gap
    a_gap: assert property (p_gap) else $error("cycles too close");

    property p_sel_rd;
        @(posedge mclk_i) disable iff (rst_i)
        !out_gate_n_o |-> !chip_sel_n_o && write_strobe_n_o;
    endproperty : p_sel_rd
    a_sel_rd: assert property (p_sel_rd) else $error("read pins wrong");

    // An idle controller must leave the memory in standby with the bus released.
    property p_idle;
        @(posedge mclk_i) disable iff (rst_i)
        req_ready_o |-> chip_sel_n_o && write_strobe_n_o && !shared_data_bus_oe_o;
    endproperty : p_idle
    a_idle: assert property (p_idle) else $error("idle pins not in standby");

    // Data must outlast the strobe edge, since hold after the end may be zero.
    property p_wr_hold;
        @(posedge mclk_i) disable iff (rst_i)
        $rose(write_strobe_n_o) |-> shared_data_bus_oe_o && $stable(shared_data_bus_o);
    endproperty : p_wr_hold
    a_wr_hold: assert property (p_wr_hold) else $error("write data dropped at end");

    c_rd: cover property (@(posedge mclk_i) rsp_valid_o);
    c_wr: cover property (@(posedge mclk_i) $rose(write_strobe_n_o));
    c_lo: cover property (@(posedge mclk_i) !write_strobe_n_o && high_byte_sel_n_o);
    c_hi: cover property (@(posedge mclk_i) !write_strobe_n_o && low_byte_sel_n_o);
    c_rd_lo: cover property (@(posedge mclk_i) !out_gate_n_o && high_byte_sel_n_o);
endmodule : asr_host
`default_nettype wire

/* File: asr_params.svh */
// Timing and width constants for the static memory host controller.
`ifndef ASR_PARAMS_SVH
`define ASR_PARAMS_SVH
`define ASR_CLK_NS 100
`define ASR_ADDR_W 16
`define ASR_DATA_W 16
`define ASR_T_RC_NS 70
`define ASR_T_WC_NS 70
`define ASR_T_WP_NS 50
`define ASR_T_CW_NS 60
`define ASR_T_DW_NS 30
`define ASR_T_AA_NS 70
`define ASR_T_HZ_NS 25
// Least times round up; none below one cycle.
`define ASR_CYC_UP(ns) ((((ns) + `ASR_CLK_NS - 1) / `ASR_CLK_NS) < 1 ? 1 : \
    (((ns) + `ASR_CLK_NS - 1) / `ASR_CLK_NS))
`define ASR_WP_CYC 3'(`ASR_CYC_UP(`ASR_T_CW_NS))
`define ASR_RD_CYC 3'(`ASR_CYC_UP(`ASR_T_AA_NS))
`define ASR_GAP_CYC 3'(`ASR_CYC_UP(`ASR_T_HZ_NS))
`define ASR_CNT_ZERO 3'h0
`define ASR_CNT_ONE 3'h1
`endif

/* File: asr_pkg.sv */
// Types for the static memory host controller.
`default_nettype none
package asr_pkg;
    typedef enum logic [2:0] {
        ASR_IDLE = 3'b000,
        ASR_RD = 3'b001,
        ASR_WR = 3'b010,
        ASR_WEND = 3'b011,
        ASR_GAP = 3'b100
    } asr_state_t;
endpackage : asr_pkg
`default_nettype wire

/* File: asr_mem_model.sv */
// Behavioural model of the 64K x 16 static memory seen from its pins.
`timescale 1ns/1ns
`default_nettype none
module asr_mem_model (
    // Memory pins.
    input wire logic [15:0] word_index_i,
    input wire logic chip_sel_n_i,
    input wire logic out_gate_n_i,
    input wire logic write_strobe_n_i,
    input wire logic low_byte_sel_n_i,
    input wire logic high_byte_sel_n_i,
    input wire logic [15:0] shared_data_bus_i,
    // Level of the bus where the host does not drive it.
    output logic [15:0] shared_data_bus_o
);
    // Words stay unknown until written and need no refresh.
    logic [15:0] mem [0:65535];
    logic [15:0] last = 16'h0000;
    logic sel, wr, rd;
    assign sel = !chip_sel_n_i && !(low_byte_sel_n_i && high_byte_sel_n_i);
    assign wr = sel && !write_strobe_n_i;
    assign rd = sel && !out_gate_n_i && write_strobe_n_i;
    always @(*) begin
        if (wr && !low_byte_sel_n_i) mem[word_index_i][7:0] = shared_data_bus_i[7:0];
        if (wr && !high_byte_sel_n_i) mem[word_index_i][15:8] = shared_data_bus_i[15:8];
    end
    // Released lanes show the inverse of the last level, so a stale value never passes.
    always @(*) begin
        shared_data_bus_o = ~last;
        // Zero-delay access is inside every access limit; the host must still wait its full time.
        if (rd && !low_byte_sel_n_i) shared_data_bus_o[7:0] = mem[word_index_i][7:0];
        if (rd && !high_byte_sel_n_i) shared_data_bus_o[15:8] = mem[word_index_i][15:8];
    end
    always @(posedge chip_sel_n_i) last <= shared_data_bus_o;
endmodule : asr_mem_model
`default_nettype wire

/* File: tb_asr_host.sv */
// Self-checking bench for the static memory host controller.
`timescale 1ns/1ns
`default_nettype none
module tb_asr_host;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic req_i = 1'b0;
    logic req_write_i = 1'b0;
    logic [15:0] req_addr_i = 16'h0000;
    logic [15:0] req_wdata_i = 16'h0000;
    logic [1:0] req_be_i = 2'h3;
    logic req_ready_o, rsp_valid_o, cs_n, oe_n, we_n, lb_n, hb_n, host_oe;
    logic [15:0] rsp_rdata_o, addr, host_d, mem_d, bus, rd;
    int mismatches = 0;
    int cmp_count = 0;
    assign bus = host_oe ? host_d : mem_d;
    initial forever #50 mclk_i = ~mclk_i;
    asr_host dut (.mclk_i(mclk_i), .rst_i(rst_i), .req_i(req_i), .req_write_i(req_write_i),
        .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .req_be_i(req_be_i),
        .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o),
        .word_index_o(addr), .chip_sel_n_o(cs_n), .out_gate_n_o(oe_n),
        .write_strobe_n_o(we_n), .low_byte_sel_n_o(lb_n), .high_byte_sel_n_o(hb_n),
        .shared_data_bus_i(bus), .shared_data_bus_o(host_d), .shared_data_bus_oe_o(host_oe));
    asr_mem_model mem (.word_index_i(addr), .chip_sel_n_i(cs_n), .out_gate_n_i(oe_n),
        .write_strobe_n_i(we_n), .low_byte_sel_n_i(lb_n), .high_byte_sel_n_i(hb_n),
        .shared_data_bus_i(host_d), .shared_data_bus_o(mem_d));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Entered just after an edge; returns just after the edge that ends the access.
    task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] d,
            input logic [1:0] be);
        int n;
        n = 0;
        req_write_i = wr;
        req_addr_i = a;
        req_wdata_i = d;
        req_be_i = be;
        req_i = 1'b1;
        while (req_ready_o !== 1'b1 && n < 20) begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        if (n >= 20) begin
            mismatches++;
            $display("MISMATCH t=%0t request never taken", $time);
            finish_test();
        end
        @(posedge mclk_i);
        #1;
        req_i = 1'b0;
        // One edge always passes, so a following call never raises the request in this step.
        @(posedge mclk_i);
        #1;
        n = 0;
        while (!wr && rsp_valid_o !== 1'b1 && n < 20) begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        if (n >= 20) begin
            mismatches++;
            $display("MISMATCH t=%0t read never answered", $time);
            finish_test();
        end
        rd = rsp_rdata_o;
    endtask : access
    task automatic t_words();
        access(1'b1, 16'h0000, 16'ha5c3, 2'h3);
        access(1'b1, 16'hffff, 16'h5a3c, 2'h3);
        access(1'b0, 16'h0000, 16'h0000, 2'h3);
        chk(rd, 16'ha5c3);
        access(1'b0, 16'hffff, 16'h0000, 2'h3);
        chk(rd, 16'h5a3c);
    endtask : t_words
    task automatic t_lanes();
        access(1'b1, 16'h0010, 16'h1234, 2'h3);
        access(1'b1, 16'h0010, 16'h99ee, 2'h1);
        access(1'b0, 16'h0010, 16'h0000, 2'h3);
        chk(rd, 16'h12ee);
        access(1'b1, 16'h0010, 16'h7711, 2'h2);
        access(1'b0, 16'h0010, 16'h0000, 2'h1);
        chk({8'h00, rd[7:0]}, 16'h00ee);
        access(1'b0, 16'h0010, 16'h0000, 2'h2);
        chk({rd[15:8], 8'h00}, 16'h7700);
    endtask : t_lanes
    task automatic t_misc();
        access(1'b1, 16'h0020, 16'hbeef, 2'h0);
        access(1'b0, 16'h0020, 16'h0000, 2'h0);
        chk(rd, 16'hbeef);
        access(1'b0, 16'h0030, 16'h0000, 2'h3);
        chk(rd, 16'hxxxx);
        repeat (8) @(posedge mclk_i);
        #1;
        chk({13'h0000, cs_n, host_oe, req_ready_o}, 16'h0005);
    endtask : t_misc
    task automatic finish_test();
        $display("mismatches=%0d cmp_count=%0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    initial begin
        repeat (20) @(posedge mclk_i);
        #1;
        rst_i = 1'b0;
        t_words();
        t_lanes();
        t_misc();
        finish_test();
    end
    initial begin
        #200000;
        mismatches++;
        finish_test();
    end
endmodule : tb_asr_host
`default_nettype wire
